// [verilog/vmgi_top.sv]
// Vector map selection and grouped interrupt expander with APB registers
module vmgi_top
    import vmgi_pkg::*;
(
    input  wire logic                CLK_SYS,
    input  wire logic                RST,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [12:0]         PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic                     PREADY,
    output logic      [31:0]         PRDATA,
    output logic                     PSLVERR,
    input  wire logic [95:0]         SRC_REQ,
    output logic      [11:0]         CPU_FLAG,
    input  wire logic                VEC_REQ,
    input  wire logic                VEC_RESET,
    input  wire logic [3:0]          VEC_GROUP,
    output logic                     VEC_VALID,
    output logic      [31:0]         VEC_DATA,
    output logic      [21:0]         VEC_ADDR,
    output vmgi_pkg::vmgi_vsrc_t     VEC_SOURCE,
    output logic                     LOW_RAM_PLAIN,
    output vmgi_pkg::vmgi_cmode_t    CORE_MODE
);
    import vmgi_pkg::*;

    // Lowest index wins: source 0 of a group has top priority
    function automatic logic [2:0] first_set(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = GROUP_SIZE - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    logic [15:0]        st1_reg;
    logic               exp_en_reg;
    logic               allow_reg;
    logic [NUM_SRC-1:0] flag_reg;
    logic [NUM_SRC-1:0] en_reg;
    logic [11:0]        ack_reg;
    logic [11:0]        cpu_flag_reg;
    logic               pready_reg;
    logic               tbl_ok_reg;
    logic [31:0]        prdata_reg;
    logic               pslverr_reg;
    vmgi_fstate_t       state_reg;
    logic [7:0]         vidx_reg;
    logic [15:0]        vlo_reg;
    logic [31:0]        vdata_reg;
    logic [21:0]        vaddr_reg;
    vmgi_vsrc_t         vsrc_reg;
    logic               vvalid_reg;

    // APB decode
    wire         acc      = PSEL & PENABLE;
    wire         fire     = acc & pready_reg;
    wire         wr_fire  = fire & PWRITE;
    wire         is_tbl   = PADDR[TBL_SEL_BIT];
    wire [7:0]   tbl_idx  = PADDR[9:2];
    wire [3:0]   reg_grp  = PADDR[6:3];
    wire         is_grp   = !is_tbl && PADDR[11:8] == GROUP_PAGE[3:0]
                            && !PADDR[7] && reg_grp < 4'(NUM_GROUPS)
                            && PADDR[1:0] == 2'b00;
    wire         is_gen   = is_grp && !PADDR[2];
    wire         is_st1   = PADDR == OFF_STATUS_ONE;
    wire         is_sset  = PADDR == OFF_STATUS_SET;
    wire         is_sclr  = PADDR == OFF_STATUS_CLR;
    wire         is_allow = PADDR == OFF_WRITE_ALLOW;
    wire         is_cflag = PADDR == OFF_CPU_FLAG;
    wire         is_ctl   = PADDR == OFF_EXP_CONTROL;
    wire         is_ack   = PADDR == OFF_GROUP_ACK;
    wire         is_tword = is_tbl && PADDR[11:10] == 2'b00
                            && PADDR[1:0] == 2'b00;
    wire         mapped   = is_grp | is_st1 | is_sset | is_sclr | is_allow
                            | is_cflag | is_ctl | is_ack | is_tword;

    wire         vector_map_select     = st1_reg[ST1_VECTOR_MAP_SELECT_BIT];
    wire         lowmap   = st1_reg[ST1_LOWRAM_BIT];
    wire         busy     = state_reg == FS_LO || state_reg == FS_HI;
    wire         tbl_wr   = wr_fire & is_tword & allow_reg;

    // Memory port: a committing APB write outranks the fetch
    wire [7:0]   fsm_idx  = (state_reg == FS_LO) ? vidx_reg
                                                 : 8'(vidx_reg + 8'h01);
    wire [7:0]   mem_addr = (busy && !tbl_wr) ? fsm_idx : tbl_idx;
    wire [15:0]  mem_rdata;

    vmgi_table_ram u_table (
        .clk   (CLK_SYS),
        .rst   (RST),
        .we    (tbl_wr),
        .addr  (mem_addr),
        .wdata (PWDATA[15:0]),
        .rdata (mem_rdata)
    );

    // Table reads wait one cycle for the registered memory output
    wire tbl_rd    = is_tword & !PWRITE;
    wire tbl_issue = acc & tbl_rd & !pready_reg & !tbl_ok_reg & !busy;
    wire pready_nx = acc & !pready_reg & (tbl_rd ? tbl_ok_reg : 1'b1);

    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0000_0000;
        if (is_st1) begin
            rd_val = {16'h0000, st1_reg};
        end else if (is_allow) begin
            rd_val = {31'h0, allow_reg};
        end else if (is_cflag) begin
            rd_val = {20'h00000, cpu_flag_reg};
        end else if (is_ctl) begin
            rd_val = {31'h0, exp_en_reg};
        end else if (is_ack) begin
            rd_val = {20'h00000, ack_reg};
        end else if (is_gen) begin
            rd_val = {24'h000000, en_reg[reg_grp*GROUP_SIZE +: GROUP_SIZE]};
        end else if (is_grp) begin
            rd_val = {24'h000000, flag_reg[reg_grp*GROUP_SIZE +: GROUP_SIZE]};
        end else if (is_tword) begin
            rd_val = {16'h0000, mem_rdata};
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            pready_reg  <= 1'b0;
            tbl_ok_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= pready_nx;
            tbl_ok_reg  <= tbl_issue;
            // Error stands only beside its ready, never into the next cycle
            pslverr_reg <= pready_nx & !mapped;
            if (pready_nx) begin
                prdata_reg  <= PWRITE ? 32'h0000_0000 : rd_val;
            end
        end
    end

    // Status one, control and write permission
    logic [15:0] st1_next;
    always_comb begin
        st1_next = st1_reg;
        if (wr_fire && is_st1) begin
            st1_next = PWDATA[15:0] & ST1_MASK;
        end else if (wr_fire && is_sset) begin
            st1_next = st1_reg | (PWDATA[15:0] & ST1_MASK);
        end else if (wr_fire && is_sclr) begin
            st1_next = st1_reg & ~(PWDATA[15:0] & ST1_MASK);
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st1_reg    <= ST1_RESET;
            exp_en_reg <= 1'b0;
            allow_reg  <= 1'b0;
        end else begin
            st1_reg <= st1_next;
            if (wr_fire && is_ctl) begin
                exp_en_reg <= PWDATA[EXPCTL_ENABLE_BIT];
            end
            if (wr_fire && is_allow) begin
                allow_reg <= PWDATA[ALLOW_BIT];
            end
        end
    end

    // Vector fetch decode at request time
    wire         vg_ok    = VEC_GROUP < 4'(NUM_GROUPS);
    wire [7:0]   vg_qual  = flag_reg[VEC_GROUP*GROUP_SIZE +: GROUP_SIZE]
                            & en_reg[VEC_GROUP*GROUP_SIZE +: GROUP_SIZE];
    wire [2:0]   vg_sel   = first_set(vg_qual);
    wire         take     = state_reg == FS_IDLE && VEC_REQ;
    wire         use_exp  = !VEC_RESET && vector_map_select && exp_en_reg && vg_ok;
    wire [7:0]   exp_idx  = 8'(TBL_GROUP_BASE + {VEC_GROUP, vg_sel, 1'b0});
    wire [21:0]  int_off  = 22'({VEC_GROUP, 1'b0} + 5'h02);
    wire [95:0]  fetch_clr = (take && use_exp && |vg_qual)
                             ? (96'h1 << (VEC_GROUP*GROUP_SIZE + vg_sel))
                             : '0;
    wire [11:0]  cflag_clr = (take && vg_ok && !VEC_RESET)
                             ? 12'(12'h001 << VEC_GROUP) : 12'h000;
    wire         adv      = !tbl_wr;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_reg  <= FS_IDLE;
            vidx_reg   <= 8'h00;
            vlo_reg    <= 16'h0000;
            vdata_reg  <= 32'h0000_0000;
            vaddr_reg  <= BOOT_ROM_BLOCK_VEC_BASE;
            vsrc_reg   <= VSRC_BOOT_ROM_BLOCK;
            vvalid_reg <= 1'b0;
        end else begin
            vvalid_reg <= 1'b0;
            case (state_reg)
                FS_IDLE: begin
                    if (VEC_REQ && VEC_RESET) begin
                        vaddr_reg  <= BOOT_ROM_BLOCK_VEC_BASE;
                        vsrc_reg   <= VSRC_BOOT_ROM_BLOCK;
                        vdata_reg  <= 32'h0000_0000;
                        vvalid_reg <= 1'b1;
                    end else if (VEC_REQ && use_exp) begin
                        vidx_reg  <= exp_idx;
                        vaddr_reg <= EXP_VEC_BASE + 22'(exp_idx);
                        vsrc_reg  <= VSRC_EXP;
                        state_reg <= FS_LO;
                    end else if (VEC_REQ && vector_map_select) begin
                        vaddr_reg  <= BOOT_ROM_BLOCK_VEC_BASE + int_off;
                        vsrc_reg   <= VSRC_BOOT_ROM_BLOCK;
                        vdata_reg  <= 32'h0000_0000;
                        vvalid_reg <= 1'b1;
                    end else if (VEC_REQ) begin
                        vaddr_reg  <= RAM_VEC_BASE + int_off;
                        vsrc_reg   <= lowmap ? VSRC_RAM0 : VSRC_RAM1;
                        vdata_reg  <= 32'h0000_0000;
                        vvalid_reg <= 1'b1;
                    end
                end
                FS_LO: begin
                    if (adv) begin
                        state_reg <= FS_HI;
                    end
                end
                FS_HI: begin
                    vlo_reg <= mem_rdata;
                    if (adv) begin
                        state_reg <= FS_DONE;
                    end
                end
                FS_DONE: begin
                    vdata_reg  <= {mem_rdata, vlo_reg};
                    vvalid_reg <= 1'b1;
                    state_reg  <= FS_IDLE;
                end
                default: begin
                    state_reg <= FS_IDLE;
                end
            endcase
        end
    end

    // Per-group flag, enable, acknowledge and CPU flag
    logic [11:0] fwd;
    logic [11:0] gen_wr;
    logic [11:0] ack_next;
    logic [11:0] cflag_next;
    logic [NUM_SRC-1:0] en_next;

    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_group
        localparam int B = g * GROUP_SIZE;
        assign fwd[g] = |(flag_reg[B +: GROUP_SIZE] & en_reg[B +: GROUP_SIZE])
                        & !ack_reg[g];
        assign gen_wr[g] = wr_fire && is_gen && reg_grp == 4'(g);
        // Set wins over software clear in both
        assign ack_next[g] = fwd[g] | (ack_reg[g]
                             & !(wr_fire && is_ack && PWDATA[g]));
        assign cflag_next[g] = fwd[g] | (cpu_flag_reg[g]
                               & !(wr_fire && is_cflag && PWDATA[g])
                               & !cflag_clr[g]);

        assign en_next[B +: GROUP_SIZE] = gen_wr[g] ? PWDATA[7:0]
                                          : en_reg[B +: GROUP_SIZE];
    end

    // Flags set by sources; only a servicing fetch clears them
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            flag_reg     <= '0;
            en_reg       <= '0;
            ack_reg      <= 12'h000;
            cpu_flag_reg <= 12'h000;
        end else begin
            en_reg       <= en_next;
            flag_reg     <= SRC_REQ | (flag_reg & ~fetch_clr);
            ack_reg      <= ack_next;
            cpu_flag_reg <= cflag_next;
        end
    end

    assign PREADY        = pready_reg;
    assign PRDATA        = prdata_reg;
    assign PSLVERR       = pslverr_reg;
    assign CPU_FLAG      = cpu_flag_reg;
    assign VEC_VALID     = vvalid_reg;
    assign VEC_DATA      = vdata_reg;
    assign VEC_ADDR      = vaddr_reg;
    assign VEC_SOURCE    = vsrc_reg;
    assign LOW_RAM_PLAIN = st1_reg[ST1_VECTOR_MAP_SELECT_BIT];
    assign CORE_MODE     = vmgi_cmode_t'({st1_reg[ST1_OBJ_BIT],
                                          st1_reg[ST1_ADDR_BIT]});
endmodule

// [verilog/vmgi_pkg.sv]
// Constants, offsets and types for the vector map and group interrupt block
package vmgi_pkg;

    // Expander geometry
    localparam int NUM_GROUPS = 12;
    localparam int GROUP_SIZE = 8;
    localparam int NUM_SRC    = 96;

    // APB geometry
    localparam int ADDR_W = 13;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [12:0] OFF_STATUS_ONE   = 13'h0000;
    localparam logic [12:0] OFF_STATUS_SET   = 13'h0004;
    localparam logic [12:0] OFF_STATUS_CLR   = 13'h0008;
    localparam logic [12:0] OFF_WRITE_ALLOW  = 13'h000c;
    localparam logic [12:0] OFF_CPU_FLAG     = 13'h0010;
    localparam logic [12:0] OFF_EXP_CONTROL  = 13'h0ce0;
    localparam logic [12:0] OFF_GROUP_ACK    = 13'h0ce4;
    // Group g: enable at 0x100 + 8g, flag at 0x104 + 8g
    localparam logic [4:0]  GROUP_PAGE       = 5'h01;
    // Vector table entry i at 0x1000 + 4i
    localparam int          TBL_SEL_BIT      = 12;

    // CPU status one fields
    localparam int ST1_VECTOR_MAP_SELECT_BIT   = 3;
    localparam int ST1_LOWRAM_BIT = 11;
    localparam int ST1_OBJ_BIT    = 6;
    localparam int ST1_ADDR_BIT   = 5;
    localparam logic [15:0] ST1_RESET = 16'h0808;
    localparam logic [15:0] ST1_MASK  = 16'h0868;

    // Expander control fields
    localparam int EXPCTL_ENABLE_BIT = 0;
    localparam int ALLOW_BIT         = 0;

    // Vector table memory
    localparam int          TBL_AW         = 8;
    localparam int          TBL_DEPTH      = 256;
    localparam int          TBL_W          = 16;
    localparam logic [7:0]  TBL_GROUP_BASE = 8'h40;

    // Vector region bases (core word addresses)
    localparam logic [21:0] RAM_VEC_BASE  = 22'h000000;
    localparam logic [21:0] BOOT_ROM_BLOCK_VEC_BASE = 22'h3fffc0;
    localparam logic [21:0] EXP_VEC_BASE  = 22'h000d00;

    // Latest latch of an in-flight request after an enable clear
    localparam int FLAG_LATCH_LIMIT_CYC = 5;

    typedef enum logic [1:0] {
        VSRC_RAM1 = 2'b00,
        VSRC_RAM0 = 2'b01,
        VSRC_BOOT_ROM_BLOCK = 2'b10,
        VSRC_EXP  = 2'b11
    } vmgi_vsrc_t;

    typedef enum logic [1:0] {
        CMODE_OBJECT = 2'b00,
        CMODE_NATIVE = 2'b10,
        CMODE_SOURCE = 2'b11
    } vmgi_cmode_t;

    typedef enum logic [1:0] {
        FS_IDLE = 2'b00,
        FS_LO   = 2'b01,
        FS_HI   = 2'b10,
        FS_DONE = 2'b11
    } vmgi_fstate_t;

endpackage

// [verilog/vmgi_table_ram.sv]
// Vector table memory with registered read data
module vmgi_table_ram
    import vmgi_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              we,
    input  wire logic [TBL_AW-1:0] addr,
    input  wire logic [TBL_W-1:0]  wdata,
    output logic      [TBL_W-1:0]  rdata
);
    // Contents are undefined after reset, as software loads them
    logic [TBL_W-1:0] mem [TBL_DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    // A write leaves the read register alone so a stalled fetch keeps data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else if (!we) begin
            rdata <= mem[addr];
        end
    end
endmodule

// [testbench/vmgi_top_properties.sv]
// Port-level checker for the vector map and group interrupt block
module vmgi_top_checker
    import vmgi_pkg::*;
(
    input wire logic                  CLK_SYS,
    input wire logic                  RST,
    input wire logic                  PSEL,
    input wire logic                  PENABLE,
    input wire logic                  PREADY,
    input wire logic                  PSLVERR,
    input wire logic [95:0]           SRC_REQ,
    input wire logic [11:0]           CPU_FLAG,
    input wire logic                  VEC_REQ,
    input wire logic                  VEC_RESET,
    input wire logic [3:0]            VEC_GROUP,
    input wire logic                  VEC_VALID,
    input wire logic [21:0]           VEC_ADDR,
    input wire vmgi_pkg::vmgi_vsrc_t  VEC_SOURCE,
    input wire logic                  LOW_RAM_PLAIN,
    input wire vmgi_pkg::vmgi_cmode_t CORE_MODE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    sequence s_reset_fetch;
        VEC_REQ && VEC_RESET;
    endsequence
    sequence s_boot_answer;
        VEC_VALID && VEC_ADDR == BOOT_ROM_BLOCK_VEC_BASE && VEC_SOURCE == VSRC_BOOT_ROM_BLOCK;
    endsequence
    property p_reset_vec;
        s_reset_fetch |=> s_boot_answer;
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("reset vector not from boot ROM");
    // Outputs are still at reset values one edge after reset was seen
    property p_after_reset;
        disable iff (1'b0) RST |=> CORE_MODE == CMODE_OBJECT && LOW_RAM_PLAIN
            && VEC_SOURCE == VSRC_BOOT_ROM_BLOCK && CPU_FLAG == 12'h000;
    endproperty
    a_after_reset: assert property (p_after_reset)
        else $error("wrong state after reset");
    property p_exp_range;
        VEC_VALID && VEC_SOURCE == VSRC_EXP |->
            VEC_ADDR[21:8] == 14'h000d && LOW_RAM_PLAIN;
    endproperty
    a_exp_range: assert property (p_exp_range)
        else $error("expander vector outside its block");
    property p_ram_range;
        VEC_VALID && VEC_SOURCE inside {VSRC_RAM0, VSRC_RAM1} |->
            VEC_ADDR[21:6] == 16'h0000 && !LOW_RAM_PLAIN;
    endproperty
    a_ram_range: assert property (p_ram_range)
        else $error("low RAM vector outside its block");
    property p_boot_rom_block_range;
        VEC_VALID && VEC_SOURCE == VSRC_BOOT_ROM_BLOCK |-> VEC_ADDR[21:6] == 16'hffff;
    endproperty
    a_boot_rom_block_range: assert property (p_boot_rom_block_range)
        else $error("boot ROM vector outside its block");
    property p_fetch_answer;
        VEC_REQ |-> ##[1:8] VEC_VALID;
    endproperty
    a_fetch_answer: assert property (p_fetch_answer)
        else $error("vector fetch not answered");
    property p_fetch_clears;
        VEC_REQ && !VEC_RESET && VEC_GROUP == 4'h3 && SRC_REQ[31:24] == 8'h00
            |=> !CPU_FLAG[3];
    endproperty
    a_fetch_clears: assert property (p_fetch_clears)
        else $error("fetch left the group flag set");
    property p_apb_answer;
        PSEL && PENABLE && !PREADY |-> ##[1:4] PREADY;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("bus access not answered");
    property p_slverr;
        PSLVERR |-> PREADY && $past(PSEL) && $past(PENABLE);
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("error response outside an access");
endmodule

bind vmgi_top vmgi_top_checker vmgi_top_checker_i (
    .CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SRC_REQ(SRC_REQ),
    .CPU_FLAG(CPU_FLAG), .VEC_REQ(VEC_REQ), .VEC_RESET(VEC_RESET),
    .VEC_GROUP(VEC_GROUP), .VEC_VALID(VEC_VALID), .VEC_ADDR(VEC_ADDR),
    .VEC_SOURCE(VEC_SOURCE), .LOW_RAM_PLAIN(LOW_RAM_PLAIN),
    .CORE_MODE(CORE_MODE)
);

// [testbench/vmgi_core_model.sv]
// Processor core model issuing vector fetches and taking the answers
module vmgi_core_model
    import vmgi_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 vec_valid,
    input  wire logic [31:0]          vec_data,
    input  wire logic [21:0]          vec_addr,
    input  wire vmgi_pkg::vmgi_vsrc_t vec_source,
    output logic                      vec_req,
    output logic                      vec_reset,
    output logic      [3:0]           vec_group
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        vec_req = 1'b0;
        vec_reset = 1'b0;
        vec_group = 4'h0;
    end
    // One fetch at a time; qualifiers are scrambled once taken
    task automatic fetch(input logic rv, input logic [3:0] g, output logic ok,
                         output logic [21:0] a, output vmgi_vsrc_t s,
                         output logic [31:0] d);
        @(posedge clk);
        vec_req <= 1'b1;
        vec_reset <= rv;
        vec_group <= g;
        @(posedge clk);
        vec_req <= 1'b0;
        vec_reset <= ~rv;
        vec_group <= ~g;
        ok = 1'b0;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(negedge clk);
            if (vec_valid === 1'b1) begin
                ok = 1'b1;
                a = vec_addr;
                s = vec_source;
                d = vec_data;
            end
        end
    endtask
endmodule

// [testbench/tb_vmgi_top.sv]
// Self-checking bench for the vector map and group interrupt block
module tb_vmgi_top;
    timeunit 1ns;
    timeprecision 1ps;
    import vmgi_pkg::*;

    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
    logic        vec_req, vec_reset, vec_valid, low_ram_plain, err, ok;
    logic [12:0] paddr;
    logic [31:0] pwdata, prdata, vec_data, rd;
    logic [95:0] src_req;
    logic [11:0] cpu_flag;
    logic [3:0]  vec_group;
    logic [21:0] vec_addr;
    vmgi_vsrc_t  vec_source;
    vmgi_cmode_t core_mode;
    int          fail_count, tests_run, cycles;
    logic [31:0] mode_bits [3] = '{32'h40, 32'h60, 32'h00};
    vmgi_cmode_t mode_exp [3] = '{CMODE_NATIVE, CMODE_SOURCE, CMODE_OBJECT};

    vmgi_top vmgi_top_i (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
        .SRC_REQ(src_req), .CPU_FLAG(cpu_flag), .VEC_REQ(vec_req),
        .VEC_RESET(vec_reset), .VEC_GROUP(vec_group), .VEC_VALID(vec_valid),
        .VEC_DATA(vec_data), .VEC_ADDR(vec_addr), .VEC_SOURCE(vec_source),
        .LOW_RAM_PLAIN(low_ram_plain), .CORE_MODE(core_mode));
    vmgi_core_model vmgi_core_model_i (.clk(clk_sys), .vec_valid(vec_valid),
        .vec_data(vec_data), .vec_addr(vec_addr), .vec_source(vec_source),
        .vec_req(vec_req), .vec_reset(vec_reset), .vec_group(vec_group));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic print_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Master waits for the answer, bounded only by the bench timeout
    task automatic apb(input logic wr, input logic [12:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only PREADY or the bench timeout ends this wait
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        chk({31'h0, pready}, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [12:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    function automatic logic [12:0] tbl(input int i);
        return 13'h1000 + 13'(4 * i);
    endfunction

    task automatic fetch(input logic rv, input logic [3:0] g,
                         input logic [21:0] ea, input vmgi_vsrc_t es,
                         input logic [31:0] ed);
        logic [21:0] a;
        vmgi_vsrc_t  s;
        logic [31:0] d;
        vmgi_core_model_i.fetch(rv, g, ok, a, s, d);
        chk({31'h0, ok}, 32'h1);
        chk({10'h0, a}, {10'h0, ea});
        chk({30'h0, s}, {30'h0, es});
        chk(d, ed);
    endtask

    // Forwarding may take up to five cycles
    task automatic wait_flag(input int g, input logic exp);
        for (int n = 0; n < 5 && cpu_flag[g] !== 1'b1; n++)
            @(negedge clk_sys);
        chk({31'h0, cpu_flag[g]}, {31'h0, exp});
    endtask

    task automatic pulse(input logic [95:0] m);
        @(posedge clk_sys);
        src_req <= m;
        @(posedge clk_sys);
        src_req <= 96'h0;
    endtask

    task automatic check_reset();
        rdchk(OFF_STATUS_ONE, 32'h0000_0808);
        rdchk(OFF_EXP_CONTROL, 32'h0);
        chk({30'h0, core_mode}, {30'h0, CMODE_OBJECT});
        chk({31'h0, low_ram_plain}, 32'h1);
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            $display("CHECK FAILED at %0t: run did not finish", $time);
            print_verdict();
        end
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, src_req} = '0;
        rst = 1'b1;
        {fail_count, tests_run, cycles} = '0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        check_reset();
        fetch(1'b1, 4'h5, BOOT_ROM_BLOCK_VEC_BASE, VSRC_BOOT_ROM_BLOCK, 32'h0);
        fetch(1'b0, 4'h2, 22'h3fffc6, VSRC_BOOT_ROM_BLOCK, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(OFF_STATUS_ONE, 32'h808 | mode_bits[i]);
            rdchk(OFF_STATUS_ONE, 32'h808 | mode_bits[i]);
            chk({30'h0, core_mode}, {30'h0, mode_exp[i]});
        end
        wr(OFF_STATUS_CLR, 32'h8);
        fetch(1'b0, 4'h1, 22'h000004, VSRC_RAM0, 32'h0);
        chk({31'h0, low_ram_plain}, 32'h0);
        wr(OFF_STATUS_CLR, 32'h800);
        fetch(1'b0, 4'h1, 22'h000004, VSRC_RAM1, 32'h0);
        wr(OFF_STATUS_SET, 32'h808);
        rdchk(OFF_STATUS_ONE, 32'h808);
        wr(OFF_WRITE_ALLOW, 32'h1);
        for (int i = 0; i < 8; i++)
            wr(tbl(8'h70 + i), 32'ha000 + i);
        wr(OFF_WRITE_ALLOW, 32'h0);
        wr(tbl(8'h74), 32'h5555);
        rdchk(tbl(8'h74), 32'ha004);
        wr(OFF_EXP_CONTROL, 32'h1);
        rdchk(OFF_EXP_CONTROL, 32'h1);
        wr(13'h118, 32'h04);
        pulse(96'h5 << 24);
        wait_flag(3, 1'b1);
        rdchk(13'h11c, 32'h05);
        rdchk(OFF_GROUP_ACK, 32'h8);
        wr(13'h11c, 32'h0);
        rdchk(13'h11c, 32'h05);
        fetch(1'b0, 4'h3, 22'h000d74, VSRC_EXP, 32'ha005a004);
        rdchk(13'h11c, 32'h01);
        fetch(1'b0, 4'h3, 22'h000d70, VSRC_EXP, 32'ha001a000);
        rdchk(13'h11c, 32'h01);
        pulse(96'h4 << 24);
        wait_flag(3, 1'b0);
        wr(OFF_GROUP_ACK, 32'h8);
        wait_flag(3, 1'b1);
        wr(13'h118, 32'h0);
        repeat (5) @(posedge clk_sys);
        wait_flag(3, 1'b1);
        wr(OFF_CPU_FLAG, 32'h8);
        rdchk(OFF_CPU_FLAG, 32'h0);
        rdchk(13'h11c, 32'h05);
        // Discard the pending top source through a return-only vector
        wr(OFF_WRITE_ALLOW, 32'h1);
        wr(tbl(8'h70), 32'hbeef);
        wr(13'h118, 32'h01);
        wr(OFF_GROUP_ACK, 32'h8);
        wait_flag(3, 1'b1);
        fetch(1'b0, 4'h3, 22'h000d70, VSRC_EXP, 32'ha001beef);
        wr(tbl(8'h70), 32'ha000);
        wr(OFF_WRITE_ALLOW, 32'h0);
        rdchk(13'h11c, 32'h04);
        rdchk(tbl(8'h70), 32'ha000);
        apb(1'b0, 13'h0500, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        check_reset();
        print_verdict();
    end
endmodule
